/* verilog/irq_bank_pkg.sv */
// Package: register map, bit positions and carrier types for the irq bank
package irq_bank_pkg;

  // ==========================================================
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] flags_1_addr = 8'h00;
  localparam logic [7:0] flags_2_addr = 8'h04;
  localparam logic [7:0] flags_3_addr = 8'h08;
  localparam logic [7:0] enables_1_addr = 8'h0c;
  localparam logic [7:0] enables_2_addr = 8'h10;
  localparam logic [7:0] enables_3_addr = 8'h14;
  localparam logic [7:0] core_ctrl_addr = 8'h18;
  localparam logic [7:0] package_cfg_addr = 8'h1c;

  // ==========================================================
  // Reset values and access masks
  localparam logic [7:0] reg_reset = 8'h00;
  // Flag register 2: bit 2 unimplemented, bit 4 reserved
  localparam logic [7:0] flags_2_wmask = 8'hfb;
  localparam logic [7:0] enables_2_wmask = 8'hfb;
  // Flag register 3: bits 5 and 4 follow the serial buffers
  localparam logic [7:0] flags_3_wmask = 8'hcf;
  // Bits present only on the largest package
  localparam logic [7:0] large_only_3 = 8'hc0;
  // Bits present on the two larger packages
  localparam logic [7:0] mid_only_3 = 8'h30;
  localparam logic [7:0] psp_bit_1 = 8'h80;
  localparam logic [7:0] full_mask = 8'hff;

  // ==========================================================
  // Bit positions
  localparam int cc2_bit = 0;
  localparam int timer_three_count_bit = 1;
  localparam int bcl1_bit = 3;
  localparam int eth_bit = 5;
  localparam int cmp_bit = 6;
  localparam int osc_bit = 7;
  localparam int tmr4_bit = 3;
  localparam int tx2_bit = 4;
  localparam int rx2_bit = 5;
  localparam int bcl2_bit = 6;
  localparam int ssp2_bit = 7;
  localparam int cc3_bit = 0;
  localparam int ctrl_peripheral_global_enable_bit = 0;
  localparam int ctrl_priority_levels_enable_bit = 1;
  localparam int cfg_pkg_lsb = 0;
  localparam int cfg_mcu_bit = 2;

  // Package size codes
  localparam logic [1:0] pkg_small = 2'h0;
  localparam logic [1:0] pkg_mid = 2'h1;
  localparam logic [1:0] pkg_large = 2'h2;

  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Capture/compare unit modes
  typedef enum logic [1:0] {
    cc_off = 2'h0,
    cc_capture = 2'h1,
    cc_compare = 2'h3,
    cc_pwm = 2'h2
  } cc_mode_t;

  // Events from the peripherals, one-cycle pulses or levels
  typedef struct packed {
    logic osc_fail;
    logic comparator;
    logic ethernet;
    logic collision_one;
    logic timer_three_ovf;
    logic sync_two_done;
    logic collision_two;
    logic rx_two_full;
    logic tx_two_empty;
    logic timer_four_match;
    logic [3:0] cc_capture_ev;
    logic [3:0] cc_compare_ev;
  } periph_events_t;

  // Whole state of the bank
  typedef struct packed {
    logic [7:0] flags_1;
    logic [7:0] flags_2;
    logic [7:0] flags_3;
    logic [7:0] enables_1;
    logic [7:0] enables_2;
    logic [7:0] enables_3;
    logic [1:0] core_ctrl;
    logic [2:0] package_cfg;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic aw_held;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bank_state_t;

endpackage : irq_bank_pkg

/* verilog/peripheral_irq_flag_enable.sv */
// Peripheral interrupt flag and enable bank with an AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none

// Function
// R01 - Any Ethernet event sets its flag
// R02 - Bus collisions set sticky collision flags
// R03 - Timer three overflow sets sticky flag
// R04 - Capture events set capture/compare unit flags
// R05 - Compare matches set capture/compare unit flags
// R06 - PWM mode never sets unit flags
// R07 - Second serial unit completion sets flag
// R08 - Receive flag mirrors buffer full, read-only
// R09 - Transmit flag mirrors buffer empty, read-only
// R10 - Timer four period match sets flag
// R11 - Flag register 3 resets zero, mixed access
// R12 - No request without global enable, priorities off
// R13 - Enable register 1 layout, resets zero
// R14 - Enable register 2 layout, resets zero
// R15 - Enable register 3 layout, resets zero
// R16 - Unimplemented bit 2 reads zero
// R17 - Package size hides second serial bits
// R18 - Parallel port enable: largest package, microcontroller
// R19 - Flags set regardless of enables
// R20 - Software clears flags around enabling
// R21 - Request is OR of flag AND enable
// R22 - Software keeps reserved enable bit zero
module peripheral_irq_flag_enable
  import irq_bank_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire periph_events_t events,
  input wire logic [7:0] flags_1_set,
  input wire cc_mode_t [3:0] cc_mode,
  output logic peripheral_irq
);

  // ==========================================================
  // State registers
  bank_state_t state_reg;
  bank_state_t state_next;
  logic [7:0] flag2_set;
  logic [7:0] flag3_set;
  logic [7:0] en1_mask;
  logic [7:0] en3_mask;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_fire;
  logic rd_fire;
  logic wr_hit;
  logic [3:0] cc_fire;

  // Address decode shared by both channels
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      flags_1_addr, flags_2_addr, flags_3_addr, enables_1_addr,
      enables_2_addr, enables_3_addr, core_ctrl_addr,
      package_cfg_addr: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction : addr_known

  // ==========================================================
  // Event decode per capture/compare unit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cc
      // PWM and off modes swallow events: the flag is unused there
      assign cc_fire[gi] =
        (cc_mode[gi] == cc_capture && events.cc_capture_ev[gi]) || // R04
        (cc_mode[gi] == cc_compare && events.cc_compare_ev[gi]); // R05 R06
    end
  endgenerate

  // Set terms are not gated by any enable, so polling works
  always_comb begin
    flag2_set = 8'h00;
    flag3_set = 8'h00;
    flag2_set[osc_bit] = events.osc_fail; // R19
    flag2_set[cmp_bit] = events.comparator;
    flag2_set[eth_bit] = events.ethernet; // R01
    flag2_set[bcl1_bit] = events.collision_one; // R02
    flag2_set[timer_three_count_bit] = events.timer_three_ovf; // R03
    flag2_set[cc2_bit] = cc_fire[0]; // R04 R05
    flag3_set[ssp2_bit] = events.sync_two_done; // R07
    flag3_set[bcl2_bit] = events.collision_two; // R02
    flag3_set[tmr4_bit] = events.timer_four_match; // R10
    flag3_set[cc3_bit +: 3] = cc_fire[3:1]; // R04 R05
  end

  // Masks for bits that this package size does not have
  always_comb begin
    en3_mask = full_mask;
    en1_mask = full_mask;
    if (state_reg.package_cfg[cfg_pkg_lsb +: 2] != pkg_large) begin
      en3_mask = en3_mask & ~large_only_3; // R17
    end
    if (state_reg.package_cfg[cfg_pkg_lsb +: 2] == pkg_small) begin
      en3_mask = en3_mask & ~mid_only_3; // R17
    end
    if (state_reg.package_cfg[cfg_pkg_lsb +: 2] != pkg_large ||
        !state_reg.package_cfg[cfg_mcu_bit]) begin
      en1_mask = ~psp_bit_1; // R18
    end
  end

  // ==========================================================
  // Bus handshakes: address and data accepted in either order
  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign wr_fire = (state_reg.aw_held || (s_axi_awvalid && s_axi_awready))
    && (state_reg.w_held || (s_axi_wvalid && s_axi_wready));
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Read mux, narrow registers in the low byte
  always_comb begin
    rd_hit = addr_known(s_axi_araddr);
    case (s_axi_araddr)
      flags_1_addr: rd_byte = state_reg.flags_1;
      flags_2_addr: rd_byte = state_reg.flags_2 & flags_2_wmask; // R16
      flags_3_addr: rd_byte = state_reg.flags_3 & en3_mask;
      enables_1_addr: rd_byte = state_reg.enables_1 & en1_mask;
      enables_2_addr: rd_byte = state_reg.enables_2 & enables_2_wmask;
      enables_3_addr: rd_byte = state_reg.enables_3 & en3_mask;
      core_ctrl_addr: rd_byte = {6'h00, state_reg.core_ctrl};
      package_cfg_addr: rd_byte = {5'h00, state_reg.package_cfg};
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state: set beats software clear on every sticky flag
  always_comb begin
    logic [7:0] wa;
    logic [7:0] wd;
    wa = state_reg.aw_held ? state_reg.waddr : s_axi_awaddr;
    wd = state_reg.w_held ? state_reg.wdata[7:0] : s_axi_wdata[7:0];
    wr_hit = wr_fire && s_axi_wstrb_ok(wa);
    state_next = state_reg;
    if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
      state_next.aw_held = 1'b1;
      state_next.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
      state_next.w_held = 1'b1;
      state_next.wdata = s_axi_wdata;
    end
    // Register writes, byte lane 0 only carries data
    if (wr_hit) begin
      case (wa)
        flags_1_addr: state_next.flags_1 = wd;
        flags_2_addr: state_next.flags_2 = wd & flags_2_wmask; // R16
        flags_3_addr: begin
          state_next.flags_3 = (wd & flags_3_wmask) |
            (state_reg.flags_3 & ~flags_3_wmask); // R11
        end
        enables_1_addr: state_next.enables_1 = wd; // R13
        enables_2_addr: state_next.enables_2 = wd & enables_2_wmask; // R14
        enables_3_addr: state_next.enables_3 = wd; // R15
        core_ctrl_addr: state_next.core_ctrl = wd[1:0];
        package_cfg_addr: state_next.package_cfg = wd[2:0];
        default: state_next.core_ctrl = state_reg.core_ctrl;
      endcase
    end
    // Sticky sets applied after the write so an event is never lost
    state_next.flags_1 = state_next.flags_1 | flags_1_set;
    state_next.flags_2 = state_next.flags_2 | flag2_set; // R01 R02 R03
    state_next.flags_3 = state_next.flags_3 | flag3_set; // R07 R10
    // Buffer status bits follow the serial port directly
    state_next.flags_3[rx2_bit] = events.rx_two_full; // R08
    state_next.flags_3[tx2_bit] = events.tx_two_empty; // R09
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = addr_known(wa) ? resp_okay : resp_slverr;
    end else if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = {24'h000000, rd_byte};
      state_next.rresp = rd_hit ? resp_okay : resp_slverr;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  // Only lane 0 holds data; its strobe is checked only when the data beat is not already held
  function automatic logic s_axi_wstrb_ok(input logic [7:0] a);
    s_axi_wstrb_ok = addr_known(a) &&
      (state_reg.w_held ? 1'b1 : s_axi_wstrb[0]);
  endfunction : s_axi_wstrb_ok

  // Single register stage for the whole bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0; // R11 R13 R14 R15
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Request towards the core
  always_comb begin
    logic pending;
    pending = |(state_reg.flags_1 & state_reg.enables_1 & en1_mask) |
      |(state_reg.flags_2 & state_reg.enables_2 & enables_2_wmask) |
      |(state_reg.flags_3 & state_reg.enables_3 & en3_mask); // R21
    // With priorities on, the core's own gating takes over
    peripheral_irq = pending && (state_reg.core_ctrl[ctrl_priority_levels_enable_bit] ||
      state_reg.core_ctrl[ctrl_peripheral_global_enable_bit]); // R12
  end

  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

  // ==========================================================
  // Checks
  ethernet_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    events.ethernet |=> state_reg.flags_2[eth_bit]) // R01
    else $error("ethernet flag not set");
  collision_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    events.collision_one |=> state_reg.flags_2[bcl1_bit]) // R02
    else $error("collision flag not set");
  timer3_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    events.timer_three_ovf |=> state_reg.flags_2[timer_three_count_bit]) // R03
    else $error("timer three flag not set");
  pwm_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cc_mode[0] == cc_pwm && !state_reg.flags_2[cc2_bit] && !wr_fire)
    |=> !state_reg.flags_2[cc2_bit]) // R06
    else $error("pwm mode set unit flag");
  rx_mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.flags_3[rx2_bit] == $past(events.rx_two_full)) // R08
    else $error("receive flag does not follow buffer");
  timer4_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    events.timer_four_match |=> state_reg.flags_3[tmr4_bit]) // R10
    else $error("timer four flag not set");
  bit2_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !state_reg.flags_2[2] && !state_reg.enables_2[2]) // R16
    else $error("unimplemented bit set");
  global_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg.core_ctrl == 2'h0) |-> !peripheral_irq) // R12
    else $error("request without global enable");

endmodule : peripheral_irq_flag_enable

`default_nettype wire

/* testbench/periph_event_model.sv */
// Peripheral event source model that faces the irq bank
`timescale 1ns/1ns
`default_nettype none
module periph_event_model
  import irq_bank_pkg::*;
(
  input wire logic aclk,
  input wire logic [4:0] sel,
  input wire logic go,
  input wire logic rx_full,
  input wire logic tx_empty,
  output var periph_events_t events
);
  logic [17:0] ev;
  // ==========================================================
  // One-cycle event pulses; the serial buffers are levels, held as long
  // as the buffer state lasts, never pulsed
  // Levels are merged into the word first, so events sees one drive per edge
  always @(posedge aclk) begin
    ev = '0;
    if (go) begin
      ev[sel] = 1'b1;
    end
    ev[10] = rx_full;
    ev[9] = tx_empty;
    events <= ev;
  end
endmodule : periph_event_model
`default_nettype wire

/* testbench/peripheral_irq_flag_enable_bench.sv */
// Self-checking bench for the peripheral irq flag and enable bank
`timescale 1ns/1ns
`default_nettype none
module peripheral_irq_flag_enable_bench;
  import irq_bank_pkg::*;
  logic aclk = 0, aresetn = 0, go = 0, rxf = 0, txe = 0;
  logic [7:0] awaddr = 0, araddr = 0, f1_set = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] sel = 0;
  cc_mode_t [3:0] mode = {4{cc_capture}};
  periph_events_t ev;
  int mismatches = 0, num_checks = 0, seed = 49;
  int f1, f2, f3, e1, e2, e3, ctrl, cfg;
  int cfgs[4] = '{0, 1, 5, 2};
  // ==========================================================
  // Clock, design and event source
  always #10 aclk = ~aclk;
  peripheral_irq_flag_enable i_peripheral_irq_flag_enable (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .events(ev),
    .flags_1_set(f1_set), .cc_mode(mode), .peripheral_irq(irq));
  periph_event_model i_periph_event_model (.aclk(aclk), .sel(sel),
    .go(go), .rx_full(rxf), .tx_empty(txe), .events(ev));
  // ==========================================================
  // Reference model: absent package bits read zero but keep storage
  function automatic int m3();
    return ((cfg & 3) == 2 ? 8'hff : 8'h3f) & ((cfg & 3) != 0 ? 8'hff : 8'hcf);
  endfunction
  function automatic int mread(int a);
    case (a)
      8'h00: return f1;
      8'h04: return f2 & 8'hfb;
      8'h08: return f3 & m3();
      8'h0c: return e1 & (cfg == 6 ? 8'hff : 8'h7f);
      8'h10: return e2 & 8'hfb;
      8'h14: return e3 & m3();
      8'h18: return ctrl;
      8'h1c: return cfg;
      default: return 0;
    endcase
  endfunction
  function automatic logic exp_irq();
    int any;
    any = (mread(0) & mread(12)) | (mread(4) & mread(16));
    any = any | (mread(8) & mread(20));
    return (any != 0) && (ctrl != 0);
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========================================================
  // AXI4-Lite master; a spare edge at the end keeps drives apart
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 100);
    bready <= 1'b0;
    check("bresp", a > 8'h1c ? resp_slverr : resp_okay, bresp);
    case (a)
      8'h00: f1 = d & 8'hff;
      8'h04: f2 = d & 8'hfb;
      8'h08: f3 = (f3 & 8'h30) | (d & 8'hcf);
      8'h0c: e1 = d & 8'hff;
      8'h10: e2 = d & 8'hfb;
      8'h14: e3 = d & 8'hff;
      8'h18: ctrl = d & 3;
      8'h1c: cfg = d & 7;
      default: ;
    endcase
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 100);
    rready <= 1'b0;
    check("rresp", a > 8'h1c ? resp_slverr : resp_okay, rresp);
    if (a <= 8'h1c) check("rdata", mread(a), rdata);
    check("irq", exp_irq(), irq);
    @(posedge aclk);
  endtask
  task automatic pulse(int i);
    sel <= i[4:0];
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic set_mode(cc_mode_t m);
    for (int u = 0; u < 4; u++) mode[u] <= m;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // Watchdog: the tests take well under a thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    tally_and_finish();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd(a);
    f1_set <= 8'h01;
    @(posedge aclk);
    f1_set <= 8'h00;
    f1 = 1;
    $display("test reset done");
    wr(8'h1c, 6);
    for (int a = 12; a < 24; a += 4) begin
      wr(a, 8'hff);
      rd(a);
      wr(a, $random(seed) & 8'hef);
      rd(a);
    end
    $display("test enables done");
    for (int a = 0; a < 24; a += 4) wr(a, 0);
    for (int i = 0; i < 18; i++) if (i != 9 && i != 10) begin
      if (i < 4) set_mode(cc_compare);
      else set_mode(cc_capture);
      pulse(i);
      case (i)
        17: f2 |= 8'h80;
        16: f2 |= 8'h40;
        15: f2 |= 8'h20;
        14: f2 |= 8'h08;
        13: f2 |= 8'h02;
        12: f3 |= 8'h80;
        11: f3 |= 8'h40;
        8: f3 |= 8'h08;
        default: if (i % 4 == 0) f2 |= 1; else f3 |= 1 << (i % 4 - 1);
      endcase
      rd(4);
      rd(8);
    end
    $display("test events done");
    wr(4, 0);
    wr(8, 0);
    wr(16, 8'h20);
    pulse(15);
    f2 = 8'h20;
    for (int c = 0; c < 4; c++) begin
      wr(24, c);
      rd(24);
    end
    wr(4, 0);
    rd(4);
    $display("test request done");
    rxf <= 1'b1;
    txe <= 1'b1;
    f3 |= 8'h30;
    repeat (3) @(posedge aclk);
    wr(8, 8'hff);
    rd(8);
    rxf <= 1'b0;
    txe <= 1'b0;
    f3 &= 8'hcf;
    repeat (3) @(posedge aclk);
    rd(8);
    wr(8, 0);
    set_mode(cc_pwm);
    for (int i = 0; i < 8; i++) pulse(i);
    rd(4);
    rd(8);
    $display("test levels done");
    wr(8, 8'hff);
    wr(12, 8'hff);
    wr(20, 8'hff);
    foreach (cfgs[k]) begin
      wr(28, cfgs[k]);
      rd(8);
      rd(12);
      rd(20);
    end
    wr(8'h20, 1);
    rd(8'h20);
    $display("test package done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
